// ==== bench/pbm_mac_model.sv ====
// Purpose: MAC and negotiation engine beside the control block
// Assumes: Everything on clk_i
// Notes:   Engine starts two cycles after a restart request
`timescale 1ns/100ps
module pbm_mac_model
   import pbm_pkg::*;
(
   input  wire logic                      clk_i,
   input  wire logic                      an_restart_i,
   output logic                           tx_en_o,
   output logic [pbm_pkg::MII_W-1:0]      txd_o,
   output logic                           an_started_o
);
   logic req_d = 0;
   initial
   begin
      tx_en_o = 0;
      txd_o = 0;
      an_started_o = 0;
   end
   always @(posedge clk_i)
   begin
      tx_en_o <= ($urandom % 4) != 0;
      txd_o <= MII_W'($urandom);
      req_d <= an_restart_i;
      an_started_o <= req_d;
   end
endmodule

// ==== bench/phy_basic_mode_control_tb.sv ====
// Purpose: Self-checking bench of the basic mode control block
// Assumes: Short reset and dead-time counts
// Notes:   Reads are scored from a queue of expected words
`timescale 1ns/100ps
module phy_basic_mode_control_tb;
   import pbm_pkg::*;
   logic clk_i = 0, rst_b_i = 0, wr = 0, rd = 0, rd_d = 0, tx_d = 0, spd_i = 0;
   logic fdx_i = 0, link = 1, fault = 0, lrxdv = 0, ltxen;
   logic [7:0] addr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [2:0] strap = 0;
   logic [3:0] lrxd = 0, txd, txd_d = 0, rxd, ltxd;
   logic [1:0] mode = 0;
   logic an_en, an_rst, spd, fdx, pdn, phyrst, rxdv, col, oe, txen, ans;
   logic [15:0] exq[$], v;
   int fails = 0, cmp_count = 0;
   always #2 clk_i = ~clk_i;
   pbm_phy_basic_mode_control #(.DEAD_CYC(20), .SRST_CYC(4)) u_dut (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .negotiation_strap_select_i(strap), .link_up_i(link),
      .remote_fault_i(fault), .an_speed_100_i(spd_i), .an_full_duplex_i(fdx_i),
      .an_started_i(ans), .an_enable_o(an_en), .an_restart_o(an_rst), .speed_100_o(spd),
      .full_duplex_o(fdx), .power_down_o(pdn), .phy_reset_o(phyrst), .tx_en_i(txen),
      .txd_i(txd), .line_rxd_i(lrxd), .line_rx_dv_i(lrxdv), .line_tx_en_o(ltxen),
      .line_txd_o(ltxd), .rxd_o(rxd), .rx_dv_o(rxdv), .col_o(col), .mii_oe_o(oe));
   pbm_mac_model u_mac (.clk_i(clk_i), .an_restart_i(an_rst), .tx_en_o(txen), .txd_o(txd),
      .an_started_o(ans));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_of_test;
      $display("compares=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr_reg(input logic [15:0] d);
      @(posedge clk_i) {wr, addr, wdata} <= {1'b1, CTL_OFS, 16'hffff, d};
      @(posedge clk_i) wr <= 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      exq.push_back(e);
      @(posedge clk_i) {rd, addr} <= {1'b1, a};
      @(posedge clk_i) rd <= 0;
   endtask
   task automatic settle;
      for (int n = 0; n < 60 && phyrst !== 1'b0; n++)
         @(posedge clk_i);
      check(phyrst, 0);
      rd_reg(CTL_OFS, {2'b0, strap[1], strap[2], 3'b0, strap[0], 8'h0});
   endtask
   always @(posedge clk_i)
   begin
      if (rd_d)
         check(rdata, {16'h0, exq.pop_front()});
      if (mode == 1)
         check(col, tx_d);
      if (mode == 1)
         check({ltxen, ltxd, rxdv, rxd}, {tx_d, txd_d, lrxdv, lrxd});
      if (mode == 2)
         check({rxdv, rxd}, {tx_d, txd_d});
      if (mode == 2)
         check({ltxen, ltxd}, 5'h0);
      rd_d <= rd;
      tx_d <= txen;
      txd_d <= txd;
   end
   initial
   begin
      #100000;
      fails++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(32'hfb9d));
      strap = 3'($urandom);
      lrxd = 4'($urandom);
      lrxdv = 1'($urandom);
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1;
      settle();
      rd_reg(EVT_OFS, 16'h0000);
      rd_reg(EVT_OFS, 16'h0001);
      link <= 0;
      fault <= 1;
      repeat (2) @(posedge clk_i);
      link <= 1;
      fault <= 0;
      repeat (4) @(posedge clk_i);
      rd_reg(EVT_OFS, 16'h0002);
      rd_reg(EVT_OFS, 16'h0001);
      $display("event tests done");
      for (int i = 0; i < 6; i++)
      begin
         v = 16'($urandom) & 16'h317f;
         spd_i <= 1'($urandom);
         fdx_i <= 1'($urandom);
         wr_reg(v);
         repeat (3) @(posedge clk_i);
         check(spd, v[12] ? spd_i : v[13]);
         check(fdx, v[12] ? fdx_i : v[8]);
         check(an_en, v[12]);
         rd_reg(8'h80, v & 16'h3100);
      end
      wr_reg(16'h0e00);
      repeat (3) @(posedge clk_i);
      check({pdn, oe, an_rst}, 3'b100);
      rd_reg(CTL_OFS, 16'h0c00);
      wr_reg(16'h1200);
      @(negedge clk_i) check(an_rst, 1);
      wr_reg(16'h1000);
      @(negedge clk_i) check(an_rst, 1);
      repeat (4) @(posedge clk_i);
      check(an_rst, 0);
      rd_reg(CTL_OFS, 16'h1000);
      $display("register tests done");
      wr_reg(16'h0080);
      @(posedge clk_i);
      mode <= 1;
      repeat (30) @(posedge clk_i);
      mode <= 0;
      wr_reg(16'h4000);
      repeat (30) @(posedge clk_i);
      mode <= 2;
      repeat (30) @(posedge clk_i);
      mode <= 0;
      $display("mii tests done");
      strap <= 3'($urandom);
      wr_reg(16'h8000);
      rd_reg(CTL_OFS, 16'h8000);
      settle();
      repeat (3) @(posedge clk_i);
      $display("soft reset test done");
      end_of_test();
   end
endmodule

// ==== inc/pbm_ctl_if.sv ====
// Purpose: Control wires from the register bank to its helpers
// Assumes: All ends on clk_i
// Notes:   One modport per helper

`timescale 1ns/100ps

interface pbm_ctl_if;
   logic srst_start;
   logic srst_busy;
   logic srst_done;
   logic loop_en;
   logic iso_en;
   logic coltest_en;
   logic pdown_en;

   modport ctl (output srst_start, loop_en, iso_en, coltest_en, pdown_en,
                input  srst_busy, srst_done);
   modport seq (input srst_start, output srst_busy, srst_done);
   modport mii (input loop_en, iso_en, coltest_en, pdown_en);
endinterface

// ==== inc/pbm_pkg.sv ====
// Purpose: Shared constants and types of the basic mode control block
// Assumes: 250 MHz core clock, 32-bit register port
// Notes:   Times are kept in their own unit; dead-time and collision cycle counts derive from them, SRST_CYC is given in cycles

package pbm_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int REG_W   = 16;
   localparam int MII_W   = 4;
   localparam int STRAP_W = 3;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [ADDR_W-1:0] CTL_OFS = 8'h80;
   localparam logic [ADDR_W-1:0] EVT_OFS = 8'h8c;

   localparam int RST_B   = 15;
   localparam int LOOP_B  = 14;
   localparam int SPD_B   = 13;
   localparam int ANEN_B  = 12;
   localparam int PDN_B   = 11;
   localparam int ISO_B   = 10;
   localparam int RSTAN_B = 9;
   localparam int DUP_B   = 8;
   localparam int COLT_B  = 7;

   localparam logic [REG_W-1:0] CTL_RW_MASK = 16'h7d80;
   localparam logic [REG_W-1:0] CTL_RST_VAL = 16'h0000;

   localparam int EVT_LINK_B = 0;
   localparam int EVT_FLT_B  = 1;

   localparam int STRAP_DUP_B = 0;
   localparam int STRAP_SPD_B = 1;
   localparam int STRAP_AN_B  = 2;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int DEAD_TIME_US  = 500;
   localparam int DEAD_CYC      = DEAD_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int BIT_TIME_NS   = 10;
   localparam int COL_ON_BT     = 512;
   localparam int COL_OFF_BT    = 4;
   localparam int COL_ON_CYC    = COL_ON_BT * BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int COL_OFF_CYC   = COL_OFF_BT * BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int SRST_CYC      = 16;

   // ****************************************
   // Types and functions
   // ****************************************
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_RUN  = 3'b010,
      SEQ_DONE = 3'b100
   } pbm_seq_t;

   // Default control word built from the strap field
   function automatic logic [REG_W-1:0] pbm_strap_word(input logic [STRAP_W-1:0] strap);
      logic [REG_W-1:0] w;
      w         = CTL_RST_VAL;
      w[ANEN_B] = strap[STRAP_AN_B];
      w[SPD_B]  = strap[STRAP_SPD_B];
      w[DUP_B]  = strap[STRAP_DUP_B];
      return w;
   endfunction

endpackage

// ==== rtl/pbm_mii_path.sv ====
// Purpose: MII data path with loopback, isolation and collision test
// Assumes: MAC side signals are on clk_i
// Notes:   All MII outputs come from flip-flops

`timescale 1ns/100ps

module pbm_mii_path #(
   parameter int DEAD_CYC = pbm_pkg::DEAD_CYC
)(
   input  wire logic                   clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   ce_i,
   pbm_ctl_if.mii                      ctl,
   input  wire logic                   tx_en_i,
   input  wire logic [pbm_pkg::MII_W-1:0] txd_i,
   input  wire logic [pbm_pkg::MII_W-1:0] line_rxd_i,
   input  wire logic                   line_rx_dv_i,
   output logic                        line_tx_en_o,
   output logic [pbm_pkg::MII_W-1:0]   line_txd_o,
   output logic [pbm_pkg::MII_W-1:0]   rxd_o,
   output logic                        rx_dv_o,
   output logic                        col_o,
   output logic                        mii_oe_o
);
   import pbm_pkg::*;

   localparam int DEAD_W      = $clog2(DEAD_CYC + 1);
   localparam int COL_OFF_LIM = COL_OFF_CYC;

   logic              loop_q;
   logic [DEAD_W-1:0] dead_cnt;
   logic              dead_now;
   logic              quiet;

   assign dead_now = (dead_cnt != '0) || (ctl.loop_en && !loop_q);
   assign quiet    = ctl.pdown_en || ctl.iso_en;

   // ****************************************
   // Loopback dead time
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         loop_q <= 1'b0;
      else if (ce_i)
         loop_q <= ctl.loop_en;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         dead_cnt <= '0;
      else if (ce_i)
      begin
         if (ctl.loop_en && !loop_q)
            dead_cnt <= DEAD_W'(DEAD_CYC);
         else if (dead_cnt != '0)
            dead_cnt <= dead_cnt - 1'b1;
      end
   end

   // ****************************************
   // Receive side toward the MAC
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rxd_o   <= '0;
         rx_dv_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (quiet || (ctl.loop_en && dead_now))
         begin
            rxd_o   <= '0;
            rx_dv_o <= 1'b0;
         end
         else if (ctl.loop_en)
         begin
            rxd_o   <= txd_i;
            rx_dv_o <= tx_en_i;
         end
         else
         begin
            rxd_o   <= line_rxd_i;
            rx_dv_o <= line_rx_dv_i;
         end
      end
   end

   // ****************************************
   // Transmit side, collision, isolation
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         line_tx_en_o <= 1'b0;
         line_txd_o   <= '0;
      end
      else if (ce_i)
      begin
         line_tx_en_o <= tx_en_i && !ctl.loop_en && !quiet;
         line_txd_o   <= (ctl.loop_en || quiet) ? '0 : txd_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         col_o <= 1'b0;
      else if (ce_i)
         col_o <= ctl.coltest_en && tx_en_i && !ctl.pdown_en;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         mii_oe_o <= 1'b1;
      else if (ce_i)
         mii_oe_o <= !ctl.iso_en;
   end

   // ****************************************
   // Checks
   // ****************************************
   loop_route_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.loop_en && !dead_now && !quiet |=>
         (rxd_o == $past(txd_i)) && (rx_dv_o == $past(tx_en_i)))
      else $error("loopback data not routed to receive path");

   dead_time_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.loop_en && !loop_q |=> !rx_dv_o && (dead_cnt != '0))
      else $error("receive valid during loopback dead time");

   col_on_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.coltest_en && !ctl.pdown_en && tx_en_i |=> col_o)
      else $error("collision test did not raise collision");

   col_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && !tx_en_i |-> ##[1:COL_OFF_LIM] !col_o)
      else $error("collision held after transmit enable fell");

   isolate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.iso_en |=> !mii_oe_o && !rx_dv_o && !line_tx_en_o)
      else $error("isolated port still drives the MII");

   pdown_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.pdown_en |=> !line_tx_en_o && !col_o && !rx_dv_o)
      else $error("powered down port still active");

endmodule

// ==== rtl/pbm_phy_basic_mode_control.sv ====
// Purpose: Basic mode control register bank of a 10/100 physical layer
// Assumes: Register port on clk_i; strap and line status pins are asynchronous
// Notes:   Hard reset runs the same sequence as a software reset to load straps
//
// Added by the designer: strobed register access.

`timescale 1ns/100ps

// Functional notes
// - Registers hold 16 meaningful bits; access bits 31:16 are unused.
// - Latched status bits keep their captured level until software reads them.
// - Self-clearing bits set on their event and clear when it ends.
// - Writing one to bit 15 runs a soft reset, reads one, then restraps.
// - Bit 14 loops MII transmit data into the MII receive path.
// - After loopback enable, receive data may be absent for up to 500 us.
// - Without negotiation, bit 13 picks 100 Mb/s when one, 10 Mb/s when zero.
// - Without negotiation, bit 8 picks full duplex when one, half when zero.
// - Bit 12 enables negotiation and makes bits 13 and 8 ignored.
// - Speed, negotiation and duplex defaults come from the strap field.
// - Bit 11 powers the port down; clearing it resumes normal operation.
// - Bit 10 isolates the port from MII data; management keeps working.
// - Bit 9 restarts negotiation, holds until started, ignored if disabled.
// - Writing zero to bit 9 leaves a running negotiation untouched.
// - Collision test raises collision within 512 and drops within 4 bit times.
// - Bits 6 to 0 are reserved, read-only and read as zero.
module pbm_phy_basic_mode_control #(
   parameter int DEAD_CYC = pbm_pkg::DEAD_CYC,
   parameter int SRST_CYC = pbm_pkg::SRST_CYC
)(
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   input  wire logic                         ce_i,
   input  wire logic [pbm_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [pbm_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic                         wr_i,
   input  wire logic                         rd_i,
   output logic      [pbm_pkg::DATA_W-1:0]   rdata_o,
   input  wire logic [pbm_pkg::STRAP_W-1:0]  negotiation_strap_select_i,
   input  wire logic                         link_up_i,
   input  wire logic                         remote_fault_i,
   input  wire logic                         an_speed_100_i,
   input  wire logic                         an_full_duplex_i,
   input  wire logic                         an_started_i,
   output logic                              an_enable_o,
   output logic                              an_restart_o,
   output logic                              speed_100_o,
   output logic                              full_duplex_o,
   output logic                              power_down_o,
   output logic                              phy_reset_o,
   input  wire logic                         tx_en_i,
   input  wire logic [pbm_pkg::MII_W-1:0]    txd_i,
   input  wire logic [pbm_pkg::MII_W-1:0]    line_rxd_i,
   input  wire logic                         line_rx_dv_i,
   output logic                              line_tx_en_o,
   output logic      [pbm_pkg::MII_W-1:0]    line_txd_o,
   output logic      [pbm_pkg::MII_W-1:0]    rxd_o,
   output logic                              rx_dv_o,
   output logic                              col_o,
   output logic                              mii_oe_o
);
   import pbm_pkg::*;

   localparam int SYNC_W = STRAP_W + 2;

   pbm_ctl_if ctl_if ();

   logic [SYNC_W-1:0]  sync_meta;
   logic [SYNC_W-1:0]  sync_q;
   logic [STRAP_W-1:0] strap_s;
   logic               link_s;
   logic               fault_s;

   logic               wr_ctl;
   logic               wr_ok;
   logic               rd_evt;
   logic [REG_W-1:0]   ctl_rw;
   logic               ctl_srst;
   logic               ctl_restart;
   logic               link_ll;
   logic               fault_lh;
   logic [REG_W-1:0]   ctl_view;
   logic [REG_W-1:0]   evt_view;
   logic [DATA_W-1:0]  next_rdata;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sync_meta <= '0;
         sync_q    <= '0;
      end
      else if (ce_i)
      begin
         sync_meta <= {remote_fault_i, link_up_i, negotiation_strap_select_i};
         sync_q    <= sync_meta;
      end
   end

   assign strap_s = sync_q[STRAP_W-1:0];
   assign link_s  = sync_q[STRAP_W];
   assign fault_s = sync_q[STRAP_W+1];

   // ****************************************
   // Register port decode
   // ****************************************
   assign wr_ctl = wr_i && (addr_i == CTL_OFS);
   assign wr_ok  = wr_ctl && !ctl_if.srst_busy;
   assign rd_evt = rd_i && (addr_i == EVT_OFS);

   assign ctl_if.srst_start = ce_i && wr_ok && wdata_i[RST_B];

   // ****************************************
   // Control word
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ctl_rw <= CTL_RST_VAL;
      else if (ce_i)
      begin
         if (ctl_if.srst_done)
            ctl_rw <= pbm_strap_word(strap_s);
         else if (wr_ok)
            ctl_rw <= wdata_i[REG_W-1:0] & CTL_RW_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ctl_srst <= 1'b0;
      else if (ce_i)
      begin
         if (ctl_if.srst_done)
            ctl_srst <= 1'b0;
         else if (wr_ok && wdata_i[RST_B])
            ctl_srst <= 1'b1;
      end
   end

   // Set wins over the started clear; a zero in bit 9 never clears, a zero in bit 12 or a soft reset does
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ctl_restart <= 1'b0;
      else if (ce_i)
      begin
         if (wr_ok && wdata_i[RSTAN_B] && wdata_i[ANEN_B] && !wdata_i[RST_B])
            ctl_restart <= 1'b1;
         else if (an_started_i || !ctl_rw[ANEN_B] || ctl_if.srst_busy)
            ctl_restart <= 1'b0;
      end
   end

   // ****************************************
   // Operating mode outputs
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         speed_100_o   <= 1'b0;
         full_duplex_o <= 1'b0;
         an_enable_o   <= 1'b0;
         power_down_o  <= 1'b0;
      end
      else if (ce_i)
      begin
         speed_100_o   <= ctl_rw[ANEN_B] ? an_speed_100_i : ctl_rw[SPD_B];
         full_duplex_o <= ctl_rw[ANEN_B] ? an_full_duplex_i : ctl_rw[DUP_B];
         an_enable_o   <= ctl_rw[ANEN_B];
         power_down_o  <= ctl_rw[PDN_B];
      end
   end

   assign an_restart_o = ctl_restart;
   assign phy_reset_o  = ctl_if.srst_busy;

   assign ctl_if.loop_en    = ctl_rw[LOOP_B];
   assign ctl_if.iso_en     = ctl_rw[ISO_B];
   assign ctl_if.coltest_en = ctl_rw[COLT_B];
   assign ctl_if.pdown_en   = ctl_rw[PDN_B];

   // ****************************************
   // Latched line status
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         link_ll <= 1'b0;
      else if (ce_i)
      begin
         if (!link_s)
            link_ll <= 1'b0;
         else if (rd_evt)
            link_ll <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         fault_lh <= 1'b0;
      else if (ce_i)
      begin
         if (fault_s)
            fault_lh <= 1'b1;
         else if (rd_evt)
            fault_lh <= 1'b0;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_comb
   begin
      ctl_view          = ctl_rw & CTL_RW_MASK;
      ctl_view[RST_B]   = ctl_srst;
      ctl_view[RSTAN_B] = ctl_restart;
      evt_view             = '0;
      evt_view[EVT_LINK_B] = link_ll;
      evt_view[EVT_FLT_B]  = fault_lh;
      next_rdata        = '0;
      if (addr_i == CTL_OFS)
         next_rdata[REG_W-1:0] = ctl_view;
      else if (addr_i == EVT_OFS)
         next_rdata[REG_W-1:0] = evt_view;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rdata_o <= '0;
      else if (ce_i)
         rdata_o <= rd_i ? next_rdata : '0;
   end

   // ****************************************
   // Helpers
   // ****************************************
   pbm_reset_seq #(
      .SRST_CYC (SRST_CYC)
   ) u_seq (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .ce_i    (ce_i),
      .ctl     (ctl_if.seq)
   );

   pbm_mii_path #(
      .DEAD_CYC (DEAD_CYC)
   ) u_mii (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .ce_i         (ce_i),
      .ctl          (ctl_if.mii),
      .tx_en_i      (tx_en_i),
      .txd_i        (txd_i),
      .line_rxd_i   (line_rxd_i),
      .line_rx_dv_i (line_rx_dv_i),
      .line_tx_en_o (line_tx_en_o),
      .line_txd_o   (line_txd_o),
      .rxd_o        (rxd_o),
      .rx_dv_o      (rx_dv_o),
      .col_o        (col_o),
      .mii_oe_o     (mii_oe_o)
   );

   // ****************************************
   // Checks
   // ****************************************
   upper_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && rd_i |=> rdata_o[DATA_W-1:REG_W] == '0)
      else $error("upper half of read word not zero");

   resv_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && rd_i && (addr_i == CTL_OFS) |=> rdata_o[COLT_B-1:0] == '0)
      else $error("reserved control bits read nonzero");

   write_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && wr_ok && !wdata_i[RST_B] |=>
         ctl_rw == ($past(wdata_i[REG_W-1:0]) & CTL_RW_MASK))
      else $error("control write did not store masked value");

   srst_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && wr_ok && wdata_i[RST_B] |=> ctl_srst && phy_reset_o)
      else $error("soft reset bit not set by write");

   srst_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl_if.srst_done |=> !ctl_srst &&
         (ctl_rw == pbm_strap_word($past(strap_s))))
      else $error("soft reset did not clear or restrap");

   latch_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && !link_s |=> !link_ll)
      else $error("link drop not latched");

   latch_high_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && fault_lh && !fault_s && !rd_evt |=> fault_lh)
      else $error("latched fault lost without a read");

   speed_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i |=> speed_100_o == ($past(ctl_rw[ANEN_B]) ? $past(an_speed_100_i)
                                                   : $past(ctl_rw[SPD_B])))
      else $error("speed output does not follow selection");

   duplex_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && !ctl_rw[ANEN_B] |=> full_duplex_o == $past(ctl_rw[DUP_B]))
      else $error("duplex output does not follow bit 8");

   restart_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && wr_ok && wdata_i[RSTAN_B] && wdata_i[ANEN_B] && !wdata_i[RST_B]
         |=> an_restart_o)
      else $error("restart request not taken");

   restart_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && an_restart_o && !an_started_i && ctl_rw[ANEN_B] && !ctl_if.srst_busy
         && !(wr_ok && (!wdata_i[ANEN_B] || wdata_i[RST_B])) |=> an_restart_o)
      else $error("restart dropped before negotiation started");

   restart_end_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && an_restart_o && an_started_i && !wr_ok |=> !an_restart_o)
      else $error("restart did not self clear");

endmodule

// ==== rtl/pbm_reset_seq.sv ====
// Purpose: Software reset sequencer
// Assumes: Runs once after hard reset to load the strap defaults
// Notes:   done is a one-cycle pulse that ends the sequence

`timescale 1ns/100ps

module pbm_reset_seq #(
   parameter int SRST_CYC = pbm_pkg::SRST_CYC
)(
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic ce_i,
   pbm_ctl_if.seq    ctl
);
   import pbm_pkg::*;

   localparam int CNT_W = $clog2(SRST_CYC + 1);

   pbm_seq_t         state;
   pbm_seq_t         next_state;
   logic [CNT_W-1:0] cnt;

   // ****************************************
   // Sequence
   // ****************************************
   always_comb
   begin
      unique case (state)
         SEQ_IDLE: next_state = ctl.srst_start ? SEQ_RUN : SEQ_IDLE;
         SEQ_RUN:  next_state = (cnt == CNT_W'(SRST_CYC - 1)) ? SEQ_DONE : SEQ_RUN;
         SEQ_DONE: next_state = SEQ_IDLE;
         default:  next_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state <= SEQ_RUN;
      else if (ce_i)
         state <= next_state;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         cnt <= '0;
      else if (ce_i)
         cnt <= (state == SEQ_RUN) ? cnt + 1'b1 : '0;
   end

   assign ctl.srst_busy = (state != SEQ_IDLE);
   assign ctl.srst_done = (state == SEQ_DONE);

   // ****************************************
   // Checks
   // ****************************************
   seq_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.srst_start && !ctl.srst_busy |=> ctl.srst_busy)
      else $error("reset sequence did not start");

   done_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && ctl.srst_done |=> !ctl.srst_done && !ctl.srst_busy)
      else $error("reset sequence did not end after done");

endmodule
